// ==== shared/dio_defines.vh ====
/*
  constants for the discrete and pulse channel logic.
  assumes a 200 MHz ref_clk; included by the design file by bare name.
*/
`ifndef DIO_DEFINES_VH
`define DIO_DEFINES_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ        200
`define MS_CYCLES      (1000 * `CLK_MHZ)
`define SCAN_MIN_MS    16'd4
`define SCAN_MAX_MS    16'd43200
`define OUT_MIN_ON_MS  16'd4
`define OUT_APPLY_MS   2

// ----------------------------------------------------------------
// pulse channel functions
// ----------------------------------------------------------------
`define PF_SLOW_CNT    2'h0
`define PF_SLOW_RATE   2'h1
`define PF_FAST_CNT    2'h2
`define PF_FAST_RATE   2'h3

// ----------------------------------------------------------------
// discrete output modes
// ----------------------------------------------------------------
`define DM_LATCH       2'h0
`define DM_TOGGLE      2'h1
`define DM_MOMENT      2'h2
`define DM_TIMED       2'h3

// slow path filter: 125 Hz max, half period 4 ms -> require 1 ms stable
`define SLOW_FILT_MS   1
`define FAST_FILT_CYC  8'h04

`endif

// ==== design/discrete_io_channel_logic.v ====
/*
  channel logic: eight discrete inputs, two pulse inputs, five discrete
  outputs, all configured over plain ports by host software.
  assumes field inputs already synchronous to ref_clk and debounced
  electrically; indicators and outputs are active high levels.
*/
// Notes on behaviour
// - each input momentary or latched, per channel
// - latched input holds active until latch reset
// - per-channel inversion of sensed field signal
// - count transitions, accumulate on and off time
// - scan interval programmable 4 to 43200 ms
// - current flowing reports active, interrupted reports open
// - one indicator per input, lit when active
// - pulse channels: slow/fast counter or rate
// - report pulse total or rate per period
// - fast path to 12 kHz, slow below 125 Hz
// - one indicator per pulse channel when active
// - outputs latched, toggled, momentary or timed
// - on reset keep last value or fail-safe
// - output command applied at once, under 2 ms
// - minimum on-time accepted down to 4 ms
// - one indicator per output, lit when active
`timescale 1ns/100ps
`include "dio_defines.vh"

module discrete_io_channel_logic #(
  parameter NDI      = 8,                  // discrete input channels
  parameter NPI      = 2,                  // pulse input channels
  parameter NDO      = 5,                  // discrete output channels
  parameter MS_TICK  = `MS_CYCLES,         // cycles per millisecond
  parameter CW       = 32                  // statistic counter width
) (
  input  wire                ref_clk,          // 200 MHz clock
  input  wire                sys_rst,          // async reset, high
  input  wire [NDI-1:0]      di_current,       // 1 = current flows in contact
  input  wire [NDI-1:0]      di_latch_en,      // 1 = latched mode
  input  wire [NDI-1:0]      di_invert,        // 1 = invert field signal
  input  wire [NDI-1:0]      di_latch_clr,     // pulse: clear latch
  input  wire [15:0]         scan_ms,          // scan interval, ms
  input  wire [2:0]          stat_sel,         // channel for statistics
  output reg  [NDI-1:0]      di_state,         // reported state
  output reg  [NDI-1:0]      di_led,           // input indicators
  output reg  [CW-1:0]       di_trans_cnt,     // transitions, chosen channel
  output reg  [CW-1:0]       di_on_ms,         // on time ms, chosen channel
  output reg  [CW-1:0]       di_off_ms,        // off time ms, chosen channel
  input  wire [NPI-1:0]      pi_slow,          // slow field input
  input  wire [NPI-1:0]      pi_fast,          // fast field input
  input  wire [2*NPI-1:0]    pi_func,          // function per channel
  input  wire [15:0]         pi_period_ms,     // rate measurement period
  output reg  [2*CW-1:0]     pi_value,         // total or rate per channel
  output reg  [NPI-1:0]      pi_led,           // pulse indicators
  input  wire [2*NDO-1:0]    do_mode,          // mode per output
  input  wire [NDO-1:0]      do_cmd,           // pulse: command strobe
  input  wire [NDO-1:0]      do_cmd_val,       // commanded value
  input  wire [15:0]         do_on_ms,         // on-time / toggle half period
  input  wire [15:0]         do_dur_ms,        // timed duration
  input  wire [NDO-1:0]      do_keep_last,     // 1 = keep last on reset
  input  wire [NDO-1:0]      do_failsafe,      // fail-safe value
  input  wire                do_soft_rst,      // pulse: output reset event
  output reg  [NDO-1:0]      do_out,           // field outputs
  output reg  [NDO-1:0]      do_led            // output indicators
);

  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  reg [31:0] ms_cnt;        // cycle counter
  reg        ms_tick;       // one-cycle pulse each ms
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ms_cnt  <= 32'h0;
      ms_tick <= 1'b0;
    end else if (ms_cnt == MS_TICK - 1) begin
      ms_cnt  <= 32'h0;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt  <= ms_cnt + 32'h1;
      ms_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // scan timer
  // ----------------------------------------------------------------
  wire [15:0] scan_lim;     // clamped interval
  assign scan_lim = (scan_ms < `SCAN_MIN_MS) ? `SCAN_MIN_MS :
                    (scan_ms > `SCAN_MAX_MS) ? `SCAN_MAX_MS : scan_ms;
  reg [15:0] scan_cnt;      // ms since last scan
  reg        scan_go;       // scan strobe
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scan_cnt <= 16'h0;
      scan_go  <= 1'b0;
    end else begin
      scan_go <= 1'b0;
      if (ms_tick) begin
        if (scan_cnt >= scan_lim - 16'h1) begin
          scan_cnt <= 16'h0;
          scan_go  <= 1'b1;
        end else begin
          scan_cnt <= scan_cnt + 16'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // discrete inputs
  // ----------------------------------------------------------------
  reg [NDI-1:0] raw_q;              // sampled level after inversion
  reg [CW-1:0]  trans [0:NDI-1];    // transition counts
  reg [CW-1:0]  on_t  [0:NDI-1];    // on time, ms
  reg [CW-1:0]  off_t [0:NDI-1];    // off time, ms
  wire [NDI-1:0] sensed;            // after inversion
  assign sensed = di_current ^ di_invert;
  integer i;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      raw_q    <= {NDI{1'b0}};
      di_state <= {NDI{1'b0}};
      di_led   <= {NDI{1'b0}};
      for (i = 0; i < NDI; i = i + 1) begin
        trans[i] <= {CW{1'b0}};
        on_t[i]  <= {CW{1'b0}};
        off_t[i] <= {CW{1'b0}};
      end
    end else begin
      for (i = 0; i < NDI; i = i + 1) begin
        // sample at each scan
        if (scan_go) begin
          raw_q[i] <= sensed[i];
          if (sensed[i] != raw_q[i])
            trans[i] <= trans[i] + 1'b1;
        end
        // reported state: latch set beats clear
        if (scan_go && sensed[i]) begin
          di_state[i] <= 1'b1;
          di_led[i]   <= 1'b1;
        end else if (di_latch_en[i]) begin
          if (di_latch_clr[i]) begin
            di_state[i] <= 1'b0;
            di_led[i]   <= 1'b0;
          end
        end else if (scan_go) begin
          di_state[i] <= 1'b0;
          di_led[i]   <= 1'b0;
        end
        // time accumulation on raw level
        if (ms_tick) begin
          if (raw_q[i])
            on_t[i] <= on_t[i] + 1'b1;
          else
            off_t[i] <= off_t[i] + 1'b1;
        end
      end
    end
  end

  // statistics readout
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      di_trans_cnt <= {CW{1'b0}};
      di_on_ms     <= {CW{1'b0}};
      di_off_ms    <= {CW{1'b0}};
    end else begin
      di_trans_cnt <= trans[stat_sel];
      di_on_ms     <= on_t[stat_sel];
      di_off_ms    <= off_t[stat_sel];
    end
  end

  // ----------------------------------------------------------------
  // pulse inputs
  // ----------------------------------------------------------------
  reg [NPI-1:0] p_lvl;              // filtered level
  reg [31:0]    p_flt [0:NPI-1];    // stability counter
  reg [CW-1:0]  p_acc [0:NPI-1];    // pulses this period / total
  reg [15:0]    per_cnt;            // ms in period
  reg           per_go;             // period end
  integer j;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_cnt <= 16'h0;
      per_go  <= 1'b0;
    end else begin
      per_go <= 1'b0;
      if (ms_tick) begin
        if (per_cnt >= pi_period_ms - 16'h1) begin
          per_cnt <= 16'h0;
          per_go  <= 1'b1;
        end else begin
          per_cnt <= per_cnt + 16'h1;
        end
      end
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      p_lvl    <= {NPI{1'b0}};
      pi_led   <= {NPI{1'b0}};
      pi_value <= {2*CW{1'b0}};
      for (j = 0; j < NPI; j = j + 1) begin
        p_flt[j] <= 32'h0;
        p_acc[j] <= {CW{1'b0}};
      end
    end else begin
      for (j = 0; j < NPI; j = j + 1) begin : pch
        reg       fast;             // fast path selected
        reg       src;              // chosen pin
        reg [31:0] need;            // stable cycles required
        fast = pi_func[2*j+1];
        src  = fast ? pi_fast[j] : pi_slow[j];
        need = fast ? {24'h0, `FAST_FILT_CYC} : MS_TICK * `SLOW_FILT_MS;
        if (src == p_lvl[j]) begin
          p_flt[j] <= 32'h0;
        end else if (p_flt[j] >= need - 1) begin
          p_flt[j] <= 32'h0;
          p_lvl[j] <= src;
        end else begin
          p_flt[j] <= p_flt[j] + 32'h1;
        end
        pi_led[j] <= p_lvl[j];
        // rising edge of filtered level counts one pulse
        if (pi_func[2*j]) begin
          if (per_go) begin
            pi_value[j*CW +: CW] <= p_acc[j];
            p_acc[j] <= (src != p_lvl[j] && p_flt[j] >= need - 1 && src)
                        ? {{(CW-1){1'b0}}, 1'b1} : {CW{1'b0}};
          end else if (src != p_lvl[j] && p_flt[j] >= need - 1 && src) begin
            p_acc[j] <= p_acc[j] + 1'b1;
          end
        end else begin
          if (src != p_lvl[j] && p_flt[j] >= need - 1 && src)
            p_acc[j] <= p_acc[j] + 1'b1;
          pi_value[j*CW +: CW] <= p_acc[j];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // discrete outputs
  // ----------------------------------------------------------------
  reg [15:0] d_tmr [0:NDO-1];   // ms remaining in phase
  wire [15:0] on_lim;           // on-time, floor of 4 ms
  assign on_lim = (do_on_ms < `OUT_MIN_ON_MS) ? `OUT_MIN_ON_MS : do_on_ms;
  integer k;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      do_out <= {NDO{1'b0}};
      do_led <= {NDO{1'b0}};
      for (k = 0; k < NDO; k = k + 1)
        d_tmr[k] <= 16'h0;
    end else begin
      for (k = 0; k < NDO; k = k + 1) begin
        if (do_soft_rst) begin
          if (!do_keep_last[k])
            do_out[k] <= do_failsafe[k];
          d_tmr[k] <= 16'h0;
        end else if (do_cmd[k]) begin
          // command applied next edge, far inside 2 ms
          case (do_mode[2*k +: 2])
            `DM_LATCH:  do_out[k] <= do_cmd_val[k];
            `DM_TOGGLE: begin
              do_out[k] <= do_cmd_val[k];
              d_tmr[k]  <= do_cmd_val[k] ? on_lim : 16'h0;
            end
            `DM_MOMENT: begin
              if (do_cmd_val[k]) begin
                do_out[k] <= 1'b1;
                d_tmr[k]  <= on_lim;
              end
            end
            `DM_TIMED: begin
              do_out[k] <= do_cmd_val[k] && (do_dur_ms != 16'h0);
              d_tmr[k]  <= do_cmd_val[k] ? do_dur_ms : 16'h0;
            end
            default: do_out[k] <= do_cmd_val[k];
          endcase
        end else if (ms_tick && d_tmr[k] != 16'h0) begin
          if (d_tmr[k] == 16'h1) begin
            if (do_mode[2*k +: 2] == `DM_TOGGLE) begin
              do_out[k] <= ~do_out[k];
              d_tmr[k]  <= on_lim;
            end else begin
              do_out[k] <= 1'b0;
              d_tmr[k]  <= 16'h0;
            end
          end else begin
            d_tmr[k] <= d_tmr[k] - 16'h1;
          end
        end
      end
      do_led <= do_out;
    end
  end

endmodule // discrete_io_channel_logic

// ==== tb/io_checker_properties.sv ====
/*
  checker: timing and mode relations at the ports of the channel logic.
  assumes the default channel counts and the header dio_defines.vh.
*/
`timescale 1ns/100ps
`include "dio_defines.vh"

module io_checker (
  input wire logic       ref_clk,      // clock
  input wire logic       sys_rst,      // async reset, high
  input wire logic [7:0] di_latch_en,  // latched mode per input
  input wire logic [7:0] di_latch_clr, // latch clear
  input wire logic [7:0] di_state,     // reported input state
  input wire logic [7:0] di_led,       // input indicators
  input wire logic [9:0] do_mode,      // output modes
  input wire logic [4:0] do_cmd,       // command strobes
  input wire logic [4:0] do_cmd_val,   // command values
  input wire logic [4:0] do_keep_last, // keep last on reset
  input wire logic [4:0] do_failsafe,  // fail-safe values
  input wire logic       do_soft_rst,  // output reset event
  input wire logic [4:0] do_out,       // field outputs
  input wire logic [4:0] do_led        // output indicators
);
  // ----------------------------------------------------------------
  // output channel 0 and input 3 relations, indicators on all discrete inputs and outputs
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire cmd0 = do_cmd[0] && !do_soft_rst; // command not overridden

  AST_DI_LED: assert property (di_led == di_state)
    else $error("input indicator differs from state");
  AST_DO_LED: assert property (do_led == $past(do_out))
    else $error("output indicator not one cycle behind output");
  AST_LATCH_CMD: assert property (cmd0 && do_mode[1:0] == `DM_LATCH
    |=> do_out[0] == $past(do_cmd_val[0])) else $error("latched command not applied");
  AST_MOMENT_ON: assert property (cmd0 && do_mode[1:0] == `DM_MOMENT && do_cmd_val[0]
    |=> do_out[0] [*8]) else $error("momentary output too short");
  AST_TIMED_ON: assert property (cmd0 && do_mode[1:0] == `DM_TIMED && do_cmd_val[0]
    |=> do_out[0] [*8]) else $error("timed output too short");
  AST_FAILSAFE: assert property (do_soft_rst && !do_keep_last[0]
    |=> do_out[0] == $past(do_failsafe[0])) else $error("fail-safe value not applied");
  AST_KEEP_LAST: assert property (do_soft_rst && do_keep_last[0] |=> $stable(do_out[0]))
    else $error("kept output changed on reset");
  AST_DI_HOLD: assert property (di_latch_en[3] && di_state[3] && !di_latch_clr[3]
    |=> di_state[3]) else $error("latched input dropped without clear");
  cover property (cmd0 && do_mode[1:0] == `DM_MOMENT && do_cmd_val[0]);
  cover property (do_soft_rst);
  cover property ($fell(di_state[3]));
endmodule // io_checker

bind discrete_io_channel_logic io_checker io_checker_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .di_latch_en(di_latch_en),
  .di_latch_clr(di_latch_clr), .di_state(di_state), .di_led(di_led),
  .do_mode(do_mode), .do_cmd(do_cmd), .do_cmd_val(do_cmd_val),
  .do_keep_last(do_keep_last), .do_failsafe(do_failsafe),
  .do_soft_rst(do_soft_rst), .do_out(do_out), .do_led(do_led));

// ==== tb/field_model.sv ====
/*
  field side: contacts on the discrete inputs, pulse sources on the pulse inputs.
  assumes the bench starts a source from idle and runs it whole periods.
*/
`timescale 1ns/100ps

module field_model #(
  parameter FAST_HALF = 10,  // fast source half period, cycles
  parameter SLOW_HALF = 100  // slow source half period, cycles
) (
  input  wire logic       ref_clk,    // clock
  input  wire logic [7:0] sw_closed,  // contacts closed
  input  wire logic       fast_run,   // run fast source ch0
  input  wire logic       slow_run,   // run slow source ch1
  output wire logic [7:0] di_current, // contact current
  output wire logic [1:0] pi_fast,    // fast pulse lines
  output wire logic [1:0] pi_slow     // slow pulse lines
);
  logic [7:0] fcnt = 8'h00; // fast phase count
  logic [7:0] scnt = 8'h00; // slow phase count
  logic       f0 = 1'b0;    // fast line level
  logic       s1 = 1'b0;    // slow line level
  assign di_current = sw_closed; // closed contact passes current
  assign pi_fast = {1'b0, f0};   // unused line idles open
  assign pi_slow = {s1, 1'b0};   // unused line idles open
  // square waves; a running pulse is finished before idling
  always @(posedge ref_clk) begin
    fcnt <= (!fast_run && !f0) || fcnt == FAST_HALF - 1 ? 8'h00 : fcnt + 8'h01;
    if (fcnt == FAST_HALF - 1) f0 <= !f0;
    scnt <= (!slow_run && !s1) || scnt == SLOW_HALF - 1 ? 8'h00 : scnt + 8'h01;
    if (scnt == SLOW_HALF - 1) s1 <= !s1;
  end
endmodule // field_model

// ==== tb/discrete_io_channel_logic_tb.sv ====
/*
  bench: output modes, reset event, input capture and pulse paths.
  assumes the ms tick shortened to 20 cycles; scans of 4 ms are 80 cycles.
*/
`timescale 1ns/100ps
`include "dio_defines.vh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", n, e, a); end end

module discrete_io_channel_logic_tb;
  logic ref_clk = 0, sys_rst = 1, do_soft_rst = 0, fast_run = 0, slow_run = 0;
  logic [7:0] di_current, di_latch_en = 0, di_invert = 0, di_latch_clr = 0, sw = 0;
  logic [7:0] di_state, di_led;
  logic [15:0] scan_ms = 4, pi_period_ms = 40, do_on_ms = 4, do_dur_ms = 6;
  logic [2:0] stat_sel = 0;
  logic [31:0] di_trans_cnt, di_on_ms, di_off_ms, v;
  logic [1:0] pi_slow, pi_fast, pi_led;
  logic [3:0] pi_func = 0;
  logic [63:0] pi_value;
  logic [9:0] do_mode = 0;
  logic [4:0] do_cmd = 0, do_cmd_val = 0, do_keep_last = 0, do_failsafe = 0, do_out, do_led;
  int err_total = 0, samples_checked = 0;

  always #2.5 ref_clk = ~ref_clk;
  field_model field_model_i (.ref_clk(ref_clk), .sw_closed(sw), .fast_run(fast_run),
    .slow_run(slow_run), .di_current(di_current), .pi_fast(pi_fast), .pi_slow(pi_slow));
  discrete_io_channel_logic #(.MS_TICK(20)) discrete_io_channel_logic_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .di_current(di_current), .di_latch_en(di_latch_en),
    .di_invert(di_invert), .di_latch_clr(di_latch_clr), .scan_ms(scan_ms), .stat_sel(stat_sel),
    .di_state(di_state), .di_led(di_led), .di_trans_cnt(di_trans_cnt), .di_on_ms(di_on_ms),
    .di_off_ms(di_off_ms), .pi_slow(pi_slow), .pi_fast(pi_fast), .pi_func(pi_func),
    .pi_period_ms(pi_period_ms), .pi_value(pi_value), .pi_led(pi_led), .do_mode(do_mode),
    .do_cmd(do_cmd), .do_cmd_val(do_cmd_val), .do_on_ms(do_on_ms), .do_dur_ms(do_dur_ms),
    .do_keep_last(do_keep_last), .do_failsafe(do_failsafe), .do_soft_rst(do_soft_rst),
    .do_out(do_out), .do_led(do_led));

  // ----------------------------------------------------------------
  // shared steps
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic cmd(input [1:0] m, input logic val); // one strobe on channel 0
    do_mode = {8'h00, m}; do_cmd_val[0] = val; do_cmd[0] = 1; step(1); do_cmd[0] = 0;
  endtask
  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_out_modes;
    cmd(`DM_LATCH, 1); `CHK("latch on", 1'b1, do_out[0])
    step(1); `CHK("out led", 1'b1, do_led[0])
    cmd(`DM_LATCH, 0); `CHK("latch off", 1'b0, do_out[0])
    do_on_ms = 1; step(1); cmd(`DM_MOMENT, 1); step(1); cmd(`DM_MOMENT, 0);
    `CHK("moment zero ignored", 1'b1, do_out[0])
    step(48); `CHK("moment floor", 1'b1, do_out[0])
    step(70); `CHK("moment end", 1'b0, do_out[0])
    cmd(`DM_TIMED, 1); step(90); `CHK("timed on", 1'b1, do_out[0])
    step(60); `CHK("timed end", 1'b0, do_out[0])
    do_on_ms = 4; cmd(`DM_TOGGLE, 1); step(40); `CHK("toggle high", 1'b1, do_out[0])
    step(80); `CHK("toggle low", 1'b0, do_out[0])
    cmd(`DM_TOGGLE, 0); step(2); v = do_out[0]; step(200);
    `CHK("toggle stop", 1'b0, do_out[0])
  endtask
  task automatic t_soft_rst; // ch0 to fail-safe 0, ch1 kept, ch2 to 1, ch3 command loses
    do_mode = 0; do_cmd = 5'h03; do_cmd_val = 5'h03; step(1);
    do_cmd = 5'h08; do_cmd_val = 5'h08; do_keep_last = 5'h02; do_failsafe = 5'h04;
    do_soft_rst = 1; step(1); do_soft_rst = 0; do_cmd = 0;
    `CHK("soft reset", 4'h6, do_out[3:0])
  endtask
  task automatic t_inputs;
    int k;
    di_latch_en = 8'h08; di_invert = 8'h06; sw = 8'h0b; step(200);
    `CHK("capture", 4'hd, di_state[3:0])
    `CHK("in led", 4'hd, di_led[3:0])
    sw = 8'h02; step(200); `CHK("latched hold", 4'hc, di_state[3:0])
    di_latch_clr = 8'h08; step(200); di_latch_clr = 0; step(200);
    `CHK("latch clear", 4'h4, di_state[3:0])
    scan_ms = 20; sw = 8'h03;
    for (k = 0; k < 900 && di_state[0] !== 1'b1; k++) step(1);
    sw = 8'h02; step(380); `CHK("scan hold", 1'b1, di_state[0])
    step(40); `CHK("scan next", 1'b0, di_state[0])
    step(2); `CHK("transitions", 32'h4, di_trans_cnt)
    `CHK("on time", 1'b1, di_on_ms != 0)
    `CHK("off time", 1'b1, di_off_ms != 0)
  endtask
  task automatic t_pulses;
    pi_func = {`PF_SLOW_CNT, `PF_FAST_CNT}; step(1); fast_run = 1; slow_run = 1;
    step(200); fast_run = 0; step(400); slow_run = 0; step(300);
    `CHK("fast count", 32'ha, pi_value[31:0])
    `CHK("slow count", 32'h3, pi_value[63:32])
    pi_func = {`PF_SLOW_RATE, `PF_FAST_RATE}; fast_run = 1; slow_run = 1; step(2000);
    v = pi_value[31:0]; `CHK("fast rate", 1'b1, v >= 38 && v <= 42)
    v = pi_value[63:32]; `CHK("slow rate", 1'b1, v >= 3 && v <= 5)
    wait (pi_slow[1]); step(30); `CHK("pulse led", 1'b1, pi_led[1])
    fast_run = 0; slow_run = 0;
  endtask

  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    step(5);
    sys_rst = 0;
    step(1);
    t_out_modes;
    t_soft_rst;
    t_inputs;
    t_pulses;
    stop_test;
  end
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    stop_test;
  end
endmodule // discrete_io_channel_logic_tb
